// file: tvn_regs.svh
// Register map, field layouts and reset values of the timer vector bank.
// Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
`ifndef TVN_REGS_SVH
`define TVN_REGS_SVH

// Word indices of the words (byte offset divided by four)
`define TVN_OFS_FRT_OVF    3'h0
`define TVN_OFS_PULSE_TIMER_UNIT0_AB    3'h1
`define TVN_OFS_PULSE_TIMER_UNIT0_CD    3'h2
`define TVN_OFS_PULSE_TIMER_UNIT0_OVF   3'h3
`define TVN_OFS_PULSE_TIMER_UNIT1_AB    3'h4
`define TVN_OFS_PRIO       3'h5
`define TVN_OFS_LAST       3'h6
`define TVN_NUM_RW         6

// Writable bit masks per layout
`define TVN_MASK_SINGLE    16'h7F00
`define TVN_MASK_DOUBLE    16'h7F7F
`define TVN_MASK_PRIO      16'h0FFF
`define TVN_RST_VAL        16'h0000

// Field positions
`define TVN_HI_LSB         8
`define TVN_LO_LSB         0
`define TVN_PRIO_FRT_LSB   8
`define TVN_PRIO_U0_LSB    4
`define TVN_PRIO_U1_LSB    0
`define TVN_LAST_SRC_LSB   8
`define TVN_LAST_SEEN_BIT  15

// Source numbers
`define TVN_SRC_FRT_OVF    3'h0
`define TVN_SRC_U0_A       3'h1
`define TVN_SRC_U0_B       3'h2
`define TVN_SRC_U0_C       3'h3
`define TVN_SRC_U0_D       3'h4
`define TVN_SRC_U0_OVF     3'h5
`define TVN_SRC_U1_A       3'h6
`define TVN_SRC_U1_B       3'h7

// Bus answers
`define TVN_RESP_OKAY      2'h0
`define TVN_RESP_DECERR    2'h3
`define TVN_ADDR_HI_ZERO   27'h000_0000

`endif

// file: tvn_pkg.sv
// Types shared by the timer vector bank and its selector.
// Assumes the constants of tvn_regs.svh are included where needed.
package tvn_pkg;

  typedef enum logic [0:0] {
    TVN_WR_IDLE = 1'b0,
    TVN_WR_RESP = 1'b1
  } tvn_wr_state_t;

  typedef enum logic [0:0] {
    TVN_RD_IDLE = 1'b0,
    TVN_RD_DATA = 1'b1
  } tvn_rd_state_t;

  // Highest-level pending source
  typedef struct packed {
    logic       valid;
    logic [2:0] src;
    logic [3:0] level;
  } tvn_req_t;

  // Vector handed out on acceptance
  typedef struct packed {
    logic       valid;
    logic [2:0] src;
    logic [6:0] vec;
    logic [3:0] level;
  } tvn_ans_t;

endpackage

// file: tvn_prio_sel.sv
// Picks the pending source with the highest 4-bit level.
// Assumes levels are stable register outputs; ties go to the lower source.
`timescale 1ns/100ps
`include "tvn_regs.svh"
module tvn_prio_sel (
  input  wire logic                 aclk,     // System clock
  input  wire logic                 aresetn,  // Sync reset, active low
  input  wire logic [7:0]           pend,     // Pending flags per source
  input  wire logic [7:0][3:0]      levels,   // Level per source
  output tvn_pkg::tvn_req_t         req       // Registered winner
);

  tvn_pkg::tvn_req_t req_d;
  tvn_pkg::tvn_req_t req_q;

  // Scan from high source down so the lowest index wins a tie
  always_comb begin
    req_d = '0;
    for (int i = 7; i >= 0; i--) begin
      if (pend[i] && (!req_d.valid || levels[i] >= req_d.level)) begin
        req_d.valid = 1'b1;
        req_d.src   = 3'(i);
        req_d.level = levels[i];
      end
    end
  end

  // Winner register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_q <= '0;
    end else begin
      req_q <= req_d;
    end
  end

  assign req = req_q;

endmodule

// file: tvn_vec_bank.sv
// Vector number bank for the free-running timer and pulse timer units.
// Assumes an AXI4-Lite master with one write and one read at a time.
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "tvn_regs.svh"
module tvn_vec_bank (
  input  wire logic                 aclk,         // System clock, 25 MHz
  input  wire logic                 aresetn,      // Sync reset, active low
  input  wire logic [31:0]          s_awaddr,     // Write address
  input  wire logic [2:0]           s_awprot,     // Write protection
  input  wire logic                 s_awvalid,    // Write address valid
  output logic                      s_awready,    // Write address ready
  input  wire logic [31:0]          s_wdata,      // Write data
  input  wire logic [3:0]           s_wstrb,      // Write byte enables
  input  wire logic                 s_wvalid,     // Write data valid
  output logic                      s_wready,     // Write data ready
  output logic [1:0]                s_bresp,      // Write response
  output logic                      s_bvalid,     // Write response valid
  input  wire logic                 s_bready,     // Write response ready
  input  wire logic [31:0]          s_araddr,     // Read address
  input  wire logic [2:0]           s_arprot,     // Read protection
  input  wire logic                 s_arvalid,    // Read address valid
  output logic                      s_arready,    // Read address ready
  output logic [31:0]               s_rdata,      // Read data
  output logic [1:0]                s_rresp,      // Read response
  output logic                      s_rvalid,     // Read data valid
  input  wire logic                 s_rready,     // Read data ready
  input  wire logic [7:0]           irq_pend,     // Pending source flags
  output tvn_pkg::tvn_req_t         irq_req,      // Highest pending source
  input  wire logic                 irq_accept,   // Acceptance strobe
  input  wire logic [2:0]           irq_acc_src,  // Accepted source
  output tvn_pkg::tvn_ans_t         irq_ans       // Vector for accepted one
);

  // Storage: five vector words and the level word
  logic [15:0]               regs_q [`TVN_NUM_RW];
  logic [15:0]               last_q;
  tvn_pkg::tvn_ans_t         ans_q;

  // Write path state
  tvn_pkg::tvn_wr_state_t    wr_state_q;
  logic                      aw_got_q;
  logic                      w_got_q;
  logic [31:0]               awaddr_q;
  logic [15:0]               wdata_q;
  logic [1:0]                wstrb_q;
  logic [1:0]                bresp_q;
  logic                      wr_commit;
  logic                      wr_hit;
  logic [2:0]                wr_idx;
  logic [15:0]               be_mask;

  // Read path state
  tvn_pkg::tvn_rd_state_t    rd_state_q;
  logic [31:0]               rdata_q;
  logic [1:0]                rresp_q;
  logic [2:0]                rd_idx;
  logic                      rd_hit;
  logic [15:0]               rd_val;

  // Levels per source
  logic [7:0][3:0]           src_level;

  // Writable mask of each stored word
  function automatic logic [15:0] mask_of(input logic [2:0] idx);
    case (idx)
      `TVN_OFS_FRT_OVF:  mask_of = `TVN_MASK_SINGLE;
      `TVN_OFS_PULSE_TIMER_UNIT0_OVF: mask_of = `TVN_MASK_SINGLE;
      `TVN_OFS_PULSE_TIMER_UNIT0_AB:  mask_of = `TVN_MASK_DOUBLE;
      `TVN_OFS_PULSE_TIMER_UNIT0_CD:  mask_of = `TVN_MASK_DOUBLE;
      `TVN_OFS_PULSE_TIMER_UNIT1_AB:  mask_of = `TVN_MASK_DOUBLE;
      `TVN_OFS_PRIO:     mask_of = `TVN_MASK_PRIO;
      default:           mask_of = `TVN_RST_VAL;
    endcase
  endfunction

  // Programmed vector of each source
  function automatic logic [6:0] vec_of(input logic [2:0] src,
                                        input logic [15:0] f_ovf,
                                        input logic [15:0] u0_ab,
                                        input logic [15:0] u0_cd,
                                        input logic [15:0] u0_ovf,
                                        input logic [15:0] u1_ab);
    case (src)
      `TVN_SRC_FRT_OVF: vec_of = f_ovf[`TVN_HI_LSB +: 7];
      `TVN_SRC_U0_A:    vec_of = u0_ab[`TVN_HI_LSB +: 7];
      `TVN_SRC_U0_B:    vec_of = u0_ab[`TVN_LO_LSB +: 7];
      `TVN_SRC_U0_C:    vec_of = u0_cd[`TVN_HI_LSB +: 7];
      `TVN_SRC_U0_D:    vec_of = u0_cd[`TVN_LO_LSB +: 7];
      `TVN_SRC_U0_OVF:  vec_of = u0_ovf[`TVN_HI_LSB +: 7];
      `TVN_SRC_U1_A:    vec_of = u1_ab[`TVN_HI_LSB +: 7];
      `TVN_SRC_U1_B:    vec_of = u1_ab[`TVN_LO_LSB +: 7];
      default:          vec_of = 7'h00;
    endcase
  endfunction

  // Handshake outputs
  assign s_awready = (wr_state_q == tvn_pkg::TVN_WR_IDLE) && !aw_got_q;
  assign s_wready  = (wr_state_q == tvn_pkg::TVN_WR_IDLE) && !w_got_q;
  assign s_bvalid  = (wr_state_q == tvn_pkg::TVN_WR_RESP);
  assign s_bresp   = bresp_q;
  assign s_arready = (rd_state_q == tvn_pkg::TVN_RD_IDLE);
  assign s_rvalid  = (rd_state_q == tvn_pkg::TVN_RD_DATA);
  assign s_rdata   = rdata_q;
  assign s_rresp   = rresp_q;

  // Write decode, commits once address and data are both held
  assign wr_commit = (wr_state_q == tvn_pkg::TVN_WR_IDLE) &&
                     aw_got_q && w_got_q;
  assign wr_idx    = awaddr_q[4:2];
  assign wr_hit    = (awaddr_q[31:5] == `TVN_ADDR_HI_ZERO) &&
                     (awaddr_q[1:0] == 2'h0) &&
                     (wr_idx < `TVN_OFS_LAST);
  assign be_mask   = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  // Write address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
    end else if (s_awvalid && s_awready) begin
      aw_got_q <= 1'b1;
      awaddr_q <= s_awaddr;
    end else if (wr_commit) begin
      aw_got_q <= 1'b0;
    end
  end

  // Write data capture, upper half is beyond the 16-bit words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_q <= 1'b0;
      wdata_q <= 16'h0000;
      wstrb_q <= 2'h0;
    end else if (s_wvalid && s_wready) begin
      w_got_q <= 1'b1;
      wdata_q <= s_wdata[15:0];
      wstrb_q <= s_wstrb[1:0];
    end else if (wr_commit) begin
      w_got_q <= 1'b0;
    end
  end

  // Write response state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= tvn_pkg::TVN_WR_IDLE;
      bresp_q    <= `TVN_RESP_OKAY;
    end else begin
      case (wr_state_q)
        tvn_pkg::TVN_WR_IDLE: begin
          if (wr_commit) begin
            wr_state_q <= tvn_pkg::TVN_WR_RESP;
            bresp_q    <= wr_hit ? `TVN_RESP_OKAY : `TVN_RESP_DECERR;
          end
        end
        tvn_pkg::TVN_WR_RESP: begin
          if (s_bready) begin
            wr_state_q <= tvn_pkg::TVN_WR_IDLE;
          end
        end
        default: begin
          wr_state_q <= tvn_pkg::TVN_WR_IDLE;
        end
      endcase
    end
  end

  // Stored words; only reset and bus writes change them, so standby
  // or a clock halt keeps whatever software programmed
  for (genvar gi = 0; gi < `TVN_NUM_RW; gi++) begin : g_word
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        regs_q[gi] <= `TVN_RST_VAL;
      end else if (wr_commit && wr_hit && (wr_idx == 3'(gi))) begin
        // Reserved bits are dropped whatever is written
        regs_q[gi] <= ((regs_q[gi] & ~be_mask) | (wdata_q & be_mask)) &
                      mask_of(3'(gi));
      end
    end
  end

  // Read decode
  assign rd_idx = s_araddr[4:2];
  assign rd_hit = (s_araddr[31:5] == `TVN_ADDR_HI_ZERO) &&
                  (s_araddr[1:0] == 2'h0) &&
                  (rd_idx <= `TVN_OFS_LAST);

  // Read mux, reserved bits already zero in storage
  always_comb begin
    rd_val = 16'h0000;
    if (rd_idx == `TVN_OFS_LAST) begin
      rd_val = last_q;
    end else if (rd_idx < `TVN_OFS_LAST) begin
      rd_val = regs_q[rd_idx] & mask_of(rd_idx);
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_q <= tvn_pkg::TVN_RD_IDLE;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= `TVN_RESP_OKAY;
    end else begin
      case (rd_state_q)
        tvn_pkg::TVN_RD_IDLE: begin
          if (s_arvalid) begin
            rd_state_q <= tvn_pkg::TVN_RD_DATA;
            rdata_q    <= rd_hit ? {16'h0000, rd_val} : 32'h0000_0000;
            rresp_q    <= rd_hit ? `TVN_RESP_OKAY : `TVN_RESP_DECERR;
          end
        end
        tvn_pkg::TVN_RD_DATA: begin
          if (s_rready) begin
            rd_state_q <= tvn_pkg::TVN_RD_IDLE;
          end
        end
        default: begin
          rd_state_q <= tvn_pkg::TVN_RD_IDLE;
        end
      endcase
    end
  end

  // Level of each source from its timer group
  for (genvar gs = 0; gs < 8; gs++) begin : g_level
    if (gs == 0) begin : g_frt
      assign src_level[gs] =
        regs_q[`TVN_OFS_PRIO][`TVN_PRIO_FRT_LSB +: 4];
    end else if (gs < 6) begin : g_u0
      assign src_level[gs] =
        regs_q[`TVN_OFS_PRIO][`TVN_PRIO_U0_LSB +: 4];
    end else begin : g_u1
      assign src_level[gs] =
        regs_q[`TVN_OFS_PRIO][`TVN_PRIO_U1_LSB +: 4];
    end
  end

  // Highest pending source for the core
  tvn_prio_sel u_sel (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pend    (irq_pend),
    .levels  (src_level),
    .req     (irq_req)
  );

  // Vector answer one cycle after acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ans_q <= '0;
    end else begin
      ans_q.valid <= irq_accept;
      if (irq_accept) begin
        ans_q.src   <= irq_acc_src;
        ans_q.vec   <= vec_of(irq_acc_src,
                              regs_q[`TVN_OFS_FRT_OVF],
                              regs_q[`TVN_OFS_PULSE_TIMER_UNIT0_AB],
                              regs_q[`TVN_OFS_PULSE_TIMER_UNIT0_CD],
                              regs_q[`TVN_OFS_PULSE_TIMER_UNIT0_OVF],
                              regs_q[`TVN_OFS_PULSE_TIMER_UNIT1_AB]);
        ans_q.level <= src_level[irq_acc_src];
      end
    end
  end

  assign irq_ans = ans_q;

  // Last accepted source and vector, readable by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_q <= 16'h0000;
    end else if (irq_accept) begin
      last_q <= 16'h0000;
      last_q[`TVN_LAST_SEEN_BIT] <= 1'b1;
      last_q[`TVN_LAST_SRC_LSB +: 3] <= irq_acc_src;
      last_q[`TVN_LO_LSB +: 7] <= vec_of(irq_acc_src,
                                         regs_q[`TVN_OFS_FRT_OVF],
                                         regs_q[`TVN_OFS_PULSE_TIMER_UNIT0_AB],
                                         regs_q[`TVN_OFS_PULSE_TIMER_UNIT0_CD],
                                         regs_q[`TVN_OFS_PULSE_TIMER_UNIT0_OVF],
                                         regs_q[`TVN_OFS_PULSE_TIMER_UNIT1_AB]);
    end
  end

endmodule

// file: tvn_vec_bank_props.sv
// Timing, protocol and field checks on the bus and acceptance ports of the vector bank.
// Assumes it is bound to tvn_vec_bank and sees that module's ports only.
`timescale 1ns/100ps
`include "tvn_regs.svh"
module tvn_vec_bank_props (
  input wire logic              aclk,         // Clock
  input wire logic              aresetn,      // Sync reset, active low
  input wire logic              s_awvalid,    // Write address valid
  input wire logic              s_awready,    // Write address ready
  input wire logic              s_wvalid,     // Write data valid
  input wire logic              s_wready,     // Write data ready
  input wire logic [1:0]        s_bresp,      // Write response
  input wire logic              s_bvalid,     // Write response valid
  input wire logic              s_bready,     // Write response ready
  input wire logic [31:0]       s_araddr,     // Read address
  input wire logic              s_arvalid,    // Read address valid
  input wire logic              s_arready,    // Read address ready
  input wire logic [31:0]       s_rdata,      // Read data
  input wire logic [1:0]        s_rresp,      // Read response
  input wire logic              s_rvalid,     // Read data valid
  input wire logic              s_rready,     // Read data ready
  input wire logic              irq_accept,   // Acceptance strobe
  input wire logic [2:0]        irq_acc_src,  // Accepted source
  input wire tvn_pkg::tvn_ans_t irq_ans       // Vector answer
);
  logic [31:0] raddr_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Address of the read now being answered
  always_ff @(posedge aclk) begin
    if (!aresetn) raddr_q <= 32'hFFFF_FFFF;
    else if (s_arvalid && s_arready) raddr_q <= s_araddr;
  end

  single_resv_a: assert property (s_rvalid && (raddr_q == 32'h0 ||
    raddr_q == 32'hC) |-> (s_rdata & 32'hFFFF_80FF) == 32'h0)
    else $error("reserved bits set in single-field word");
  dbl_resv_a: assert property (s_rvalid && (raddr_q == 32'h4 ||
    raddr_q == 32'h8 || raddr_q == 32'h10) |-> (s_rdata & 32'hFFFF_8080) == 0)
    else $error("reserved bits set in double-field word");
  bad_read_a: assert property (s_arvalid && s_arready && s_araddr > 32'h18
    |=> s_rresp == `TVN_RESP_DECERR && s_rdata == 32'h0)
    else $error("unmapped read not refused");
  read_lat_a: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read answer late");
  // Both taken at one edge: commit at the next, answer shows the one after
  write_lat_a: assert property (s_awvalid && s_awready && s_wvalid &&
    s_wready |-> ##2 s_bvalid) else $error("write answer late");
  r_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid &&
    $stable(s_rdata) && $stable(s_rresp)) else $error("read answer dropped");
  b_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid &&
    $stable(s_bresp)) else $error("write answer dropped");
  one_write_a: assert property (s_bvalid |-> !s_awready && !s_wready)
    else $error("write taken while answer pending");
  ans_lat_a: assert property (irq_accept |=> irq_ans.valid &&
    irq_ans.src == $past(irq_acc_src)) else $error("vector answer wrong");
  ans_pulse_a: assert property (!irq_accept |=> !irq_ans.valid)
    else $error("vector answer without acceptance");
endmodule

bind tvn_vec_bank tvn_vec_bank_props chk_u (.aclk, .aresetn, .s_awvalid,
  .s_awready, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
  .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
  .s_rready, .irq_accept, .irq_acc_src, .irq_ans);

// file: tb.sv
// Self-checking bench for the timer vector bank over AXI4-Lite.
// Assumes tvn_pkg and the bound checker are compiled before it.
`timescale 1ns/100ps
`include "tvn_regs.svh"
module tb;
  logic              aclk = 0, aresetn = 0, acc = 0;
  logic [31:0]       awaddr = 0, wdata = 0, araddr = 0, seed = 32'h0000_88EC;
  logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic              rready = 0, awrdy, wrdy, bvalid, arrdy, rvalid;
  logic [1:0]        bresp, rresp;
  logic [31:0]       rdata;
  logic [7:0]        pend = 0;
  logic [2:0]        asrc = 0;
  logic [15:0]       vw [5];
  logic [11:0]       lv = 0;
  logic [33:0]       rq [$], iq [$];
  logic [1:0]        bq [$];
  int                errors = 0, check_count = 0;
  tvn_pkg::tvn_req_t req;
  tvn_pkg::tvn_ans_t ans;
  localparam int         WIDX [8] = '{0, 1, 1, 2, 2, 3, 4, 4};
  localparam logic [7:0] HI = 8'h6B;

  // Clock, 40 ns period
  always #20 aclk = ~aclk;

  tvn_vec_bank dut_u (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr),
    .s_awprot(3'h0), .s_awvalid(awvalid), .s_awready(awrdy), .s_wdata(wdata),
    .s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wrdy), .s_bresp(bresp),
    .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arprot(3'h0),
    .s_arvalid(arvalid), .s_arready(arrdy), .s_rdata(rdata), .s_rresp(rresp),
    .s_rvalid(rvalid), .s_rready(rready), .irq_pend(pend), .irq_req(req),
    .irq_accept(acc), .irq_acc_src(asrc), .irq_ans(ans));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [6:0] vec(input int s);
    return HI[s] ? vw[WIDX[s]][14:8] : vw[WIDX[s]][6:0];
  endfunction
  function automatic logic [3:0] lvl(input int s);
    return s == 0 ? lv[11:8] : (s < 6 ? lv[7:4] : lv[3:0]);
  endfunction

  task automatic chk(input string n, input logic [33:0] g, input logic [33:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Write with random stall on the response channel
  task automatic wr(input logic [31:0] a, input logic [15:0] d, input logic [1:0] r);
    logic aw_h, w_h, b_h;
    b_h = 0;
    bq.push_back(r);
    seed = xs(seed);
    awaddr <= a;
    wdata <= {seed[31:16], d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= seed[0];
    repeat (100) if (!b_h) begin
      @(negedge aclk);
      {aw_h, w_h, b_h} = {awvalid & awrdy, wvalid & wrdy, bvalid & bready};
      @(posedge aclk);
      if (aw_h) awvalid <= 0;
      if (w_h) wvalid <= 0;
      if (!b_h) bready <= 1;
    end
    if (!b_h) errors++;
  endtask
  // Read, noting the expected response and data
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    logic ar_h, r_h;
    r_h = 0;
    rq.push_back(e);
    seed = xs(seed);
    araddr <= a;
    arvalid <= 1;
    rready <= seed[1];
    repeat (100) if (!r_h) begin
      @(negedge aclk);
      {ar_h, r_h} = {arvalid & arrdy, rvalid & rready};
      @(posedge aclk);
      if (ar_h) arvalid <= 0;
      if (!r_h) rready <= 1;
    end
    if (!r_h) errors++;
  endtask
  task automatic do_reset;
    aresetn <= 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    for (int i = 0; i < 6; i++) rd(32'(i * 4), 34'h0);
  endtask

  // Monitor compares each answer with the oldest note
  always @(negedge aclk) begin
    if (rvalid && rready && rq.size() > 0)
      chk("rdata", {rresp, rdata}, rq.pop_front());
    if (bvalid && bready && bq.size() > 0)
      chk("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
    if (ans.valid === 1'b1 && iq.size() > 0)
      chk("irq_ans", {20'h0, ans.src, ans.vec, ans.level}, iq.pop_front());
  end

  // Main sequence
  initial begin
    do_reset();
    $display("test reset values done");
    for (int p = 0; p < 4; p++) for (int i = 0; i < 5; i++) begin
      seed = xs(seed);
      vw[i] = p == 0 ? 16'hFFFF : (p == 1 ? 16'h0 : seed[15:0]);
      if (p == 3) vw[i] = vw[i] & (i == 0 || i == 3 ? 16'h7F00 : 16'h7F7F);
      wr(32'(i * 4), vw[i], `TVN_RESP_OKAY);
      vw[i] = vw[i] & (i == 0 || i == 3 ? `TVN_MASK_SINGLE : `TVN_MASK_DOUBLE);
      rd(32'(i * 4), {18'h0, vw[i]});
    end
    $display("test fields done");
    seed = xs(seed);
    lv = seed[11:0];
    wr(32'h14, {4'h0, lv}, `TVN_RESP_OKAY);
    rd(32'h1C, {`TVN_RESP_DECERR, 32'h0});
    rd(32'h2, {`TVN_RESP_DECERR, 32'h0});
    wr(32'h18, 16'hFFFF, `TVN_RESP_DECERR);
    wr(32'h20, 16'hFFFF, `TVN_RESP_DECERR);
    rd(32'h14, {22'h0, lv});
    $display("test refusals done");
    for (int s = 0; s < 8; s++) begin
      iq.push_back({20'h0, 3'(s), vec(s), lvl(s)});
      acc <= 1;
      asrc <= 3'(s);
      @(posedge aclk);
    end
    acc <= 0;
    repeat (3) @(posedge aclk);
    rd(32'h18, {18'h0, 5'h10, 3'h7, 1'b0, vec(7)});
    lv = 12'h295;
    wr(32'h14, {4'h0, lv}, `TVN_RESP_OKAY);
    pend <= 8'hC1;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("irq_req", {26'h0, req}, {26'h0, 1'b1, 3'h6, 4'h5});
    @(posedge aclk);
    pend <= 8'h01;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("irq_req", {26'h0, req}, {26'h0, 1'b1, 3'h0, 4'h2});
    @(posedge aclk);
    $display("test vectors done");
    repeat (50) begin
      seed = xs(seed);
      pend <= seed[7:0];
      @(posedge aclk);
    end
    for (int i = 0; i < 5; i++) rd(32'(i * 4), {18'h0, vw[i]});
    do_reset();
    $display("test hold and second reset done");
    conclude();
  end

  // Watchdog
  initial begin
    #800000;
    errors++;
    conclude();
  end
endmodule
